// ==== core/power_monitor_config_regs.sv ====
// register bank and measurement configuration of the power monitor
// assumes a serial front end on linkClk that frames bytes; core runs on clk
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - reading the configuration register changes no setting and no conversion
// R2 - configuration write halts conversion, then restarts with the new settings
// R3 - writing one to bit 15 resets all registers; the bit self-clears; the code keeps the shunt result at its last value
// R4 - average field 11:9 selects 1,4,16,64,128,256,512,1024 samples
// R5 - bus conversion field 8:6 selects 140 us up to 8.244 ms
// R6 - shunt conversion field 5:3 selects the same eight times
// R7 - mode 000/100 power-down; 001-011 triggered; 101-111 continuous
// R8 - mode resets to 111, continuous shunt and bus
// R9 - shunt result is 16-bit two's complement, 2.5 uV step
// R10 - with averaging the shunt result shows the averaged value
// R11 - calibration register at pointer 05h, reset zero
// R12 - alert mask/enable at 06h with ready flag, threshold at 07h
// R13 - fixed identification words at pointers FEh and FFh
// R14 - each 16-bit register moves as two bytes on the link
// R15 - configuration resets to 4127h; all others reset to zero
// R16 - configuration write clears conversion-ready unless power-down written
// R17 - unused bits 14:12 and read-only registers ignore writes
module power_monitor_config_regs #(
  parameter int CONV_CYCLES [8] = pm_pkg::CONV_CYCLES_DEF,
  // identification words: values are arbitrary
  parameter logic [15:0] MAKER_ID = 16'h0C3A,
  parameter logic [15:0] DIE_ID = 16'h0D4B
) (
  // core clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial link side
  input wire logic linkClk,
  input wire logic linkResetn,
  input wire logic linkStart,
  input wire logic linkWrValid,
  input wire logic [7:0] linkWrByte,
  input wire logic linkRdReq,
  output logic [7:0] linkRdByte,
  output logic linkRdValid,
  output logic linkBusy,
  // measurement front end
  input wire logic signed [15:0] shuntSample,
  // settings to current, power and alert logic
  output logic [15:0] scalingCalibration,
  output logic [15:0] alertMaskEnable,
  output logic [15:0] alertThreshold,
  // conversion status
  output logic convDone,
  output logic converting
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  typedef struct packed {
    logic reqS1;
    logic reqS2;
    logic reqSeen;
    logic ackTgl;
    logic [15:0] rdWord;
    pm_pkg::measCfg_t cfg;
    logic [15:0] cal;
    logic [15:0] mask;
    logic [15:0] limit;
    logic restart;
  } state_t;

  localparam state_t STATE_RESET = '{
    cfg: pm_pkg::measCfg_t'(pm_pkg::CONFIG_RESET[pm_pkg::CFG_FIELD_W-1:0]),
    cal: pm_pkg::ZERO_RESET,
    mask: pm_pkg::ZERO_RESET,
    limit: pm_pkg::ZERO_RESET,
    restart: 1'b1,
    default: '0
  };

  state_t q, d;
  logic reqToggle;
  pm_pkg::regReq_t req;
  logic [15:0] shuntResult;
  logic access;
  logic isWrite;
  logic isRead;
  logic cfgWrite;
  logic softReset;
  logic [15:0] readValue;
  logic [15:0] wrData;
  logic [pm_pkg::CFG_FIELD_W-1:0] wrFields;
  logic cvrf;

  // link-clock half of the crossing
  link_xfer u_link (
    .linkClk(linkClk),
    .linkResetn(linkResetn),
    .linkStart(linkStart),
    .linkWrValid(linkWrValid),
    .linkWrByte(linkWrByte),
    .linkRdReq(linkRdReq),
    .linkRdByte(linkRdByte),
    .linkRdValid(linkRdValid),
    .linkBusy(linkBusy),
    .reqToggle(reqToggle),
    .req(req),
    .ackToggle(q.ackTgl),
    .rdWord(q.rdWord)
  );

  conv_engine #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_conv (
    .clk(clk),
    .resetn(resetn),
    .cfg(q.cfg),
    .restart(q.restart),
    .shuntSample(shuntSample),
    .shuntResult(shuntResult),
    .convDone(convDone),
    .converting(converting)
  );

  // request word is stable while its toggle is in flight
  assign access = q.reqS2 != q.reqSeen;
  assign isWrite = access && req.write;
  assign isRead = access && !req.write;
  assign cfgWrite = isWrite && req.ptr == pm_pkg::PTR_CONFIG;
  assign softReset = cfgWrite && req.data[pm_pkg::CFG_RST_BIT];
  assign wrData = req.data;
  assign wrFields = req.data[pm_pkg::CFG_FIELD_W-1:0];

  // read multiplexer
  always_comb begin
    case (req.ptr)
      // reset bit reads zero, unused bits read their reset value [R3] [R17]
      pm_pkg::PTR_CONFIG: readValue = {1'b0, pm_pkg::CONFIG_RESET[14:12], q.cfg};
      pm_pkg::PTR_SHUNT: readValue = shuntResult; // [R9]
      pm_pkg::PTR_CAL: readValue = q.cal; // [R11]
      pm_pkg::PTR_MASK: readValue = q.mask; // [R12]
      pm_pkg::PTR_LIMIT: readValue = q.limit; // [R12]
      pm_pkg::PTR_MAKER: readValue = MAKER_ID; // [R13]
      pm_pkg::PTR_DIE: readValue = DIE_ID; // [R13]
      default: readValue = 16'h0000;
    endcase
  end

  always_comb begin
    d = q;
    d.restart = 1'b0;
    d.reqS1 = reqToggle;
    d.reqS2 = q.reqS1;
    if (access) begin
      d.reqSeen = q.reqS2;
      d.ackTgl = ~q.ackTgl;
    end
    // reads capture and move no setting, except that a mask read clears the ready flag [R1]
    if (isRead) d.rdWord = readValue;
    if (isWrite) begin
      case (req.ptr)
        pm_pkg::PTR_CONFIG: begin
          // new settings, conversion abandoned and restarted [R2]
          d.cfg = pm_pkg::measCfg_t'(wrFields);
          d.restart = 1'b1;
          if (wrFields[1:0] != 2'b00) d.mask[pm_pkg::MASK_CVRF_BIT] = 1'b0; // [R16]
        end
        pm_pkg::PTR_CAL: d.cal = wrData; // [R11]
        pm_pkg::PTR_MASK: begin
          d.mask = (wrData & pm_pkg::MASK_WRITABLE)
                 | (q.mask & ~pm_pkg::MASK_WRITABLE); // [R12]
        end
        pm_pkg::PTR_LIMIT: d.limit = wrData; // [R12]
        default: d.limit = q.limit; // read-only targets ignored [R17]
      endcase
    end
    if (isRead && req.ptr == pm_pkg::PTR_MASK) d.mask[pm_pkg::MASK_CVRF_BIT] = 1'b0;
    // a completing conversion wins over a write or read clear in the same cycle, a soft reset wins over it
    if (convDone) d.mask[pm_pkg::MASK_CVRF_BIT] = 1'b1;
    if (softReset) begin
      // same values as power-on reset [R3] [R15]
      d.cfg = STATE_RESET.cfg;
      d.cal = STATE_RESET.cal;
      d.mask = STATE_RESET.mask;
      d.limit = STATE_RESET.limit;
      d.restart = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) q <= STATE_RESET; // [R8] [R15]
    else q <= d;
  end

  assign scalingCalibration = q.cal;
  assign alertMaskEnable = q.mask;
  assign alertThreshold = q.limit;
  assign cvrf = q.mask[pm_pkg::MASK_CVRF_BIT];

  sequence s_cfg_write;
    access && req.write && req.ptr == pm_pkg::PTR_CONFIG;
  endsequence

  sequence s_cfg_read;
    access && !req.write && req.ptr == pm_pkg::PTR_CONFIG;
  endsequence

  a_cfg_read_quiet: assert property (@(posedge clk) disable iff (!resetn) // [R1]
    s_cfg_read |=> q.cfg == $past(q.cfg) && !q.restart)
    else $error("configuration read disturbed settings");

  a_write_restart: assert property (@(posedge clk) disable iff (!resetn) // [R2]
    s_cfg_write ##0 !req.data[15] |=> q.restart && q.cfg == $past(wrFields))
    else $error("configuration write did not restart with new settings");

  a_soft_reset: assert property (@(posedge clk) disable iff (!resetn) // [R3]
    s_cfg_write ##0 req.data[15] |=> q.cfg == STATE_RESET.cfg && q.cal == 16'h0000
      && q.mask == 16'h0000 && q.limit == 16'h0000 && q.restart)
    else $error("soft reset did not restore defaults");

  a_reset_default: assert property (@(posedge clk) disable iff (!resetn) // [R8] [R15]
    $rose(resetn) |-> q.cfg.mode == 3'b111 && q.cfg == STATE_RESET.cfg && q.cal == 16'h0000)
    else $error("wrong reset value");

  a_cvrf_clear: assert property (@(posedge clk) disable iff (!resetn) // [R16]
    s_cfg_write ##0 (wrFields[1:0] != 2'b00 && !convDone)
    |=> !q.mask[pm_pkg::MASK_CVRF_BIT])
    else $error("ready flag not cleared by configuration write");

  a_cfg_readback: assert property (@(posedge clk) disable iff (!resetn) // [R17]
    s_cfg_read |=> q.rdWord[15:12] == 4'h4 && q.rdWord[11:0] == $past(q.cfg))
    else $error("configuration readback wrong");

  a_ro_ignored: assert property (@(posedge clk) disable iff (!resetn) // [R17]
    isWrite && (req.ptr == pm_pkg::PTR_SHUNT || req.ptr == pm_pkg::PTR_MAKER
      || req.ptr == pm_pkg::PTR_DIE)
    |=> $stable(q.cal) && $stable(q.limit) && $stable(q.cfg) && !q.restart)
    else $error("read-only write changed state");

  a_ident_read: assert property (@(posedge clk) disable iff (!resetn) // [R13]
    isRead && req.ptr == pm_pkg::PTR_MAKER |=> q.rdWord == MAKER_ID)
    else $error("maker identity read wrong");

  a_cal_write: assert property (@(posedge clk) disable iff (!resetn) // [R11]
    isWrite && req.ptr == pm_pkg::PTR_CAL && !softReset |=> q.cal == $past(wrData))
    else $error("calibration write lost");

  a_shunt_read: assert property (@(posedge clk) disable iff (!resetn) // [R9]
    isRead && req.ptr == pm_pkg::PTR_SHUNT |=> q.rdWord == $past(shuntResult))
    else $error("shunt result read wrong");

  sequence s_mask_read;
    isRead && req.ptr == pm_pkg::PTR_MASK;
  endsequence

  sequence s_limit_write;
    isWrite && req.ptr == pm_pkg::PTR_LIMIT;
  endsequence

  a_die_read: assert property ( // [R13]
    isRead && req.ptr == pm_pkg::PTR_DIE |=> q.rdWord == DIE_ID)
    else $error("die identity read wrong");

  a_unmapped_read: assert property ( // [R17]
    isRead && req.ptr inside {[8'h08:8'hFD]} |=> q.rdWord == 16'h0000)
    else $error("unmapped read not zero");

  a_limit_write: assert property ( // [R12]
    s_limit_write |=> q.limit == $past(wrData))
    else $error("threshold write lost");

  a_limit_hold: assert property ( // [R12]
    !(isWrite && req.ptr == pm_pkg::PTR_LIMIT) && !softReset |=> $stable(q.limit))
    else $error("threshold moved");

  a_cal_hold: assert property ( // [R11]
    !(isWrite && req.ptr == pm_pkg::PTR_CAL) && !softReset |=> $stable(q.cal))
    else $error("calibration moved");

  a_cfg_hold: assert property ( // [R1]
    !cfgWrite |=> $stable(q.cfg))
    else $error("settings moved");

  a_restart_cause: assert property ( // [R1] [R2]
    q.restart && !$rose(resetn) |-> $past(cfgWrite))
    else $error("restart without write");

  a_rdword_hold: assert property ( // [R1]
    !isRead |=> $stable(q.rdWord))
    else $error("read word moved");

  a_mask_write: assert property ( // [R12]
    isWrite && req.ptr == pm_pkg::PTR_MASK |=> (q.mask & pm_pkg::MASK_WRITABLE)
      == ($past(wrData) & pm_pkg::MASK_WRITABLE))
    else $error("mask write lost");

  a_cvrf_set: assert property ( // [R16]
    convDone && !softReset |=> cvrf)
    else $error("ready flag not set");

  a_mask_read_clear: assert property ( // [R12]
    s_mask_read ##0 !convDone |=> !cvrf)
    else $error("ready flag not cleared");

  a_powerdown_keep: assert property ( // [R16]
    s_cfg_write ##0 wrFields[1:0] == 2'b00 && !softReset
    |=> cvrf == ($past(cvrf) || $past(convDone)))
    else $error("power-down moved ready flag");
endmodule // power_monitor_config_regs
`default_nettype wire

// ==== core/pm_pkg.sv ====
// constants and carrier types shared by the power monitor register bank
// assumes one core clock at 125 MHz and a byte-wide serial link front end
package pm_pkg;
  // register pointers
  localparam logic [7:0] PTR_CONFIG = 8'h00;
  localparam logic [7:0] PTR_SHUNT = 8'h01;
  localparam logic [7:0] PTR_CAL = 8'h05;
  localparam logic [7:0] PTR_MASK = 8'h06;
  localparam logic [7:0] PTR_LIMIT = 8'h07;
  localparam logic [7:0] PTR_MAKER = 8'hFE;
  localparam logic [7:0] PTR_DIE = 8'hFF;

  // reset values
  localparam logic [15:0] CONFIG_RESET = 16'h4127;
  localparam logic [15:0] ZERO_RESET = 16'h0000;

  // configuration fields
  localparam int CFG_RST_BIT = 15;
  localparam int CFG_FIELD_W = 12;
  localparam int MODE_CONT_BIT = 2;
  localparam int MODE_BUS_BIT = 1;
  localparam int MODE_SHUNT_BIT = 0;

  // alert mask/enable fields
  localparam int MASK_CVRF_BIT = 3;
  localparam logic [15:0] MASK_WRITABLE = 16'hFC03;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS [8] = '{140000, 204000, 332000, 588000,
                                      1100000, 2116000, 4156000, 8244000};
  localparam int CONV_CYCLES_DEF [8] = '{
    CONV_TIME_NS[0] / CLK_PERIOD_NS, CONV_TIME_NS[1] / CLK_PERIOD_NS,
    CONV_TIME_NS[2] / CLK_PERIOD_NS, CONV_TIME_NS[3] / CLK_PERIOD_NS,
    CONV_TIME_NS[4] / CLK_PERIOD_NS, CONV_TIME_NS[5] / CLK_PERIOD_NS,
    CONV_TIME_NS[6] / CLK_PERIOD_NS, CONV_TIME_NS[7] / CLK_PERIOD_NS};
  localparam int CONV_CYC_W = 21;

  // averaged samples are 1 << AVG_LOG2: 1,4,16,64,128,256,512,1024
  localparam int AVG_LOG2 [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  localparam int AVG_CNT_W = 10;

  typedef struct packed {
    logic [2:0] avgCode;
    logic [2:0] busCt;
    logic [2:0] shuntCt;
    logic [2:0] mode;
  } measCfg_t;

  typedef struct packed {
    logic write;
    logic [7:0] ptr;
    logic [15:0] data;
  } regReq_t;
endpackage

// ==== core/link_xfer.sv ====
// link-clock side: byte framing and toggle handshake toward the core clock
// assumes linkClk runs while a request is pending
`timescale 1ns/1ps
`default_nettype none
module link_xfer (
  // link clock
  input wire logic linkClk,
  input wire logic linkResetn,
  // byte side
  input wire logic linkStart,
  input wire logic linkWrValid,
  input wire logic [7:0] linkWrByte,
  input wire logic linkRdReq,
  output logic [7:0] linkRdByte,
  output logic linkRdValid,
  output logic linkBusy,
  // core side
  output logic reqToggle,
  output pm_pkg::regReq_t req,
  input wire logic ackToggle,
  input wire logic [15:0] rdWord
);
  typedef struct packed {
    logic [1:0] wrIdx;
    logic [7:0] ptr;
    logic [7:0] wrMsb;
    logic rdSel;
    logic pend;
    logic pendRead;
    logic reqTgl;
    logic ackS1;
    logic ackS2;
    logic ackSeen;
    logic rdValid;
    logic [7:0] rdByte;
    logic [7:0] rdLsb;
    pm_pkg::regReq_t req;
  } state_t;

  state_t q, d;

  always_comb begin
    d = q;
    d.rdValid = 1'b0;
    d.ackS1 = ackToggle;
    d.ackS2 = q.ackS1;
    if (q.ackS2 != q.ackSeen) begin
      d.ackSeen = q.ackS2;
      d.pend = 1'b0;
      if (q.pendRead) begin
        d.rdByte = rdWord[15:8];
        d.rdLsb = rdWord[7:0];
        d.rdValid = 1'b1;
        d.rdSel = 1'b1;
      end
    end
    if (linkStart) begin
      d.wrIdx = 2'd0;
      d.rdSel = 1'b0;
    end else if (linkWrValid && !q.pend) begin
      case (q.wrIdx)
        2'd0: begin
          d.ptr = linkWrByte;
          d.wrIdx = 2'd1;
        end
        2'd1: begin
          d.wrMsb = linkWrByte;
          d.wrIdx = 2'd2;
        end
        2'd2: begin
          // msb first, then lsb, forms one word [R14]
          d.req = '{write: 1'b1, ptr: q.ptr, data: {q.wrMsb, linkWrByte}};
          d.reqTgl = ~q.reqTgl;
          d.pend = 1'b1;
          d.pendRead = 1'b0;
          d.wrIdx = 2'd3;
        end
        default: d.wrIdx = 2'd3;
      endcase
    end else if (linkRdReq && !q.pend) begin
      if (!q.rdSel) begin
        d.req = '{write: 1'b0, ptr: q.ptr, data: 16'h0000};
        d.reqTgl = ~q.reqTgl;
        d.pend = 1'b1;
        d.pendRead = 1'b1;
      end else begin
        // second byte of the pair [R14]
        d.rdByte = q.rdLsb;
        d.rdValid = 1'b1;
        d.rdSel = 1'b0;
      end
    end
  end

  always_ff @(posedge linkClk) begin
    if (!linkResetn) q <= '0;
    else q <= d;
  end

  assign linkRdByte = q.rdByte;
  assign linkRdValid = q.rdValid;
  assign linkBusy = q.pend;
  assign reqToggle = q.reqTgl;
  assign req = q.req;

  a_byte_pairing: assert property (@(posedge linkClk) disable iff (!linkResetn) // [R14]
    linkWrValid && !linkStart && !q.pend && q.wrIdx == 2'd2
    |=> q.req.write && q.req.data == {$past(q.wrMsb), $past(linkWrByte)}
        && q.reqTgl != $past(q.reqTgl))
    else $error("write word not built from two bytes");
endmodule // link_xfer
`default_nettype wire

// ==== core/conv_engine.sv ====
// conversion sequencer and shunt averaging
// assumes settings only change together with a restart pulse
`timescale 1ns/1ps
`default_nettype none
module conv_engine #(
  parameter int CONV_CYCLES [8] = pm_pkg::CONV_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire pm_pkg::measCfg_t cfg,
  input wire logic restart,
  input wire logic signed [15:0] shuntSample,
  // results
  output logic [15:0] shuntResult,
  output logic convDone,
  output logic converting
);
  for (genvar i = 0; i < 8; i++) begin : g_chk
    if (CONV_CYCLES[i] < 1 || CONV_CYCLES[i] >= 2 ** pm_pkg::CONV_CYC_W)
      $error("conversion cycle count out of range");
  end

  typedef enum logic [1:0] {IDLE, SHUNT, BUS} phase_t;
  typedef struct packed {
    phase_t phase;
    logic [pm_pkg::CONV_CYC_W-1:0] timer;
    logic [pm_pkg::AVG_CNT_W-1:0] sampleCnt;
    logic signed [25:0] acc;
    logic [15:0] result;
    logic done;
  } state_t;

  state_t q, d;
  phase_t firstPhase;
  logic [2:0] ctSel;
  logic lastSample;
  logic signed [25:0] accNext;
  logic [pm_pkg::AVG_CNT_W-1:0] avgLast;

  always_comb begin
    d = q;
    d.done = 1'b0;
    // decode: bit0 shunt, bit1 bus, bit2 continuous, none = power-down [R7]
    firstPhase = cfg.mode[pm_pkg::MODE_SHUNT_BIT] ? SHUNT :
                 (cfg.mode[pm_pkg::MODE_BUS_BIT] ? BUS : IDLE);
    ctSel = (q.phase == BUS) ? cfg.busCt : cfg.shuntCt; // [R5] [R6]
    accNext = q.acc + ((q.phase == SHUNT) ? 26'(shuntSample) : 26'sd0);
    avgLast = pm_pkg::AVG_CNT_W'((1 << pm_pkg::AVG_LOG2[cfg.avgCode]) - 1); // [R4]
    lastSample = q.sampleCnt == avgLast;
    if (restart) begin
      d.phase = firstPhase;
      d.timer = '0;
      d.sampleCnt = '0;
      d.acc = '0;
    end else begin
      case (q.phase)
        IDLE: d.timer = '0;
        SHUNT, BUS: begin
          if (q.timer != pm_pkg::CONV_CYC_W'(CONV_CYCLES[ctSel] - 1)) begin
            d.timer = q.timer + 1'b1;
          end else begin
            d.timer = '0;
            d.acc = accNext;
            if (q.phase == SHUNT && cfg.mode[pm_pkg::MODE_BUS_BIT]) begin
              d.phase = BUS;
            end else begin
              d.phase = firstPhase;
              d.sampleCnt = q.sampleCnt + 1'b1;
              if (lastSample) begin
                d.sampleCnt = '0;
                d.acc = '0;
                d.done = 1'b1;
                // averaged two's complement result [R9] [R10]
                if (cfg.mode[pm_pkg::MODE_SHUNT_BIT])
                  d.result = 16'(accNext >>> pm_pkg::AVG_LOG2[cfg.avgCode]);
                if (!cfg.mode[pm_pkg::MODE_CONT_BIT]) d.phase = IDLE; // [R7]
              end
            end
          end
        end
        default: d.phase = IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) q <= '0;
    else q <= d;
  end

  assign shuntResult = q.result;
  assign convDone = q.done;
  assign converting = q.phase != IDLE;

  a_avg_count: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    $rose(convDone) |-> $past(q.sampleCnt) == $past(avgLast))
    else $error("average ended on wrong sample count");

  a_powerdown_idle: assert property (@(posedge clk) disable iff (!resetn) // [R7]
    restart && cfg.mode[1:0] == 2'b00 ##1 !restart[*3] |-> !converting[*1])
    else $error("power-down mode still converting");

  a_result_avg_only: assert property (@(posedge clk) disable iff (!resetn) // [R10]
    $changed(shuntResult) |-> convDone)
    else $error("shunt result changed outside an average end");
endmodule // conv_engine
`default_nettype wire

// ==== testbench/link_host.sv ====
// behavioural serial host on the byte-framed link of the register bank
// assumes the bench calls its tasks one at a time; link clock stands high between tasks
`timescale 1ns/1ps
`default_nettype none
module link_host (
  // link clock and reset
  output logic linkClk,
  output logic linkResetn,
  // request side
  output logic linkStart,
  output logic linkWrValid,
  output logic [7:0] linkWrByte,
  output logic linkRdReq,
  // answer side
  input wire logic [7:0] linkRdByte,
  input wire logic linkRdValid,
  input wire logic linkBusy
);
  initial begin
    linkClk = 1'b1;
    linkResetn = 1'b0;
    linkStart = 1'b0;
    linkWrValid = 1'b0;
    linkWrByte = 8'hA5;
    linkRdReq = 1'b0;
  end

  // one link period, returns just after the rising edge
  task automatic lclk();
    #61.5 linkClk = 1'b0;
    #62.5 linkClk = 1'b1;
    #1;
  endtask

  task automatic reset_link();
    linkResetn = 1'b0;
    repeat (3) lclk();
    linkResetn = 1'b1;
  endtask

  // frame start, then pointer byte
  task automatic send_ptr(input logic [7:0] ptr);
    linkStart = 1'b1;
    lclk();
    linkStart = 1'b0;
    linkWrValid = 1'b1;
    linkWrByte = ptr;
    lclk();
  endtask

  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] data, output logic ok);
    int n;
    send_ptr(ptr);
    linkWrByte = data[15:8];
    lclk();
    linkWrByte = data[7:0];
    lclk();
    linkWrValid = 1'b0;
    linkWrByte = ~data[7:0];
    n = 0;
    repeat (2) lclk();
    while (linkBusy !== 1'b0 && n < 20) begin
      lclk();
      n++;
    end
    ok = (n < 20);
  endtask

  task automatic read_reg(input logic [7:0] ptr, output logic [15:0] data, output logic ok);
    int n;
    int m;
    send_ptr(ptr);
    linkWrValid = 1'b0;
    linkWrByte = ~ptr;
    ok = 1'b1;
    for (int i = 0; i < 2; i++) begin
      m = 0;
      while (linkBusy !== 1'b0 && m < 8) begin
        lclk();
        m++;
      end
      n = 0;
      linkRdReq = 1'b1;
      lclk();
      linkRdReq = 1'b0;
      // lsb answer stands right after the edge that took the request
      while (linkRdValid !== 1'b1 && n < 8) begin
        lclk();
        n++;
      end
      ok = ok && (linkRdValid === 1'b1) && (i == 0 || n == 0);
      if (i == 0) begin
        data[15:8] = linkRdByte;
      end else begin
        data[7:0] = linkRdByte;
      end
    end
  endtask
endmodule // link_host
`default_nettype wire

// ==== testbench/power_monitor_config_regs_tb_top.sv ====
// self-checking bench for the power monitor register bank
// assumes link_host drives the byte link; core clock 125 MHz, link clock 8 MHz
`timescale 1ns/1ps
`default_nettype none
module power_monitor_config_regs_tb_top;
  localparam logic [15:0] MAKER_VAL = 16'h1A2B; // arbitrary
  localparam logic [15:0] DIE_VAL = 16'h3C4D; // arbitrary
  localparam int CYC [8] = '{20, 21, 22, 23, 24, 25, 26, 27};
  localparam logic [7:0] PTRS [6] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'hFE, 8'hFF};
  localparam logic [7:0] RWP [3] = '{8'h05, 8'h06, 8'h07};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic linkClk, linkResetn, linkStart, linkWrValid, linkRdReq, linkRdValid, linkBusy;
  logic [7:0] linkWrByte, linkRdByte;
  logic signed [15:0] shuntSample = 16'sh0000;
  logic signed [15:0] samp [4];
  logic [15:0] cal, mask, limit, rdata, d;
  logic convDone, converting, ok;
  logic [15:0] mdl [256];
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int doneCnt = 0;
  int seed = 32'hBF2B0679;
  int s, d0;

  always #4 clk = ~clk;

  link_host i_host (.linkClk(linkClk), .linkResetn(linkResetn), .linkStart(linkStart),
    .linkWrValid(linkWrValid), .linkWrByte(linkWrByte), .linkRdReq(linkRdReq),
    .linkRdByte(linkRdByte), .linkRdValid(linkRdValid), .linkBusy(linkBusy));

  power_monitor_config_regs #(.CONV_CYCLES(CYC), .MAKER_ID(MAKER_VAL), .DIE_ID(DIE_VAL)) i_dut (
    .clk(clk), .resetn(resetn), .linkClk(linkClk), .linkResetn(linkResetn),
    .linkStart(linkStart), .linkWrValid(linkWrValid), .linkWrByte(linkWrByte),
    .linkRdReq(linkRdReq), .linkRdByte(linkRdByte), .linkRdValid(linkRdValid),
    .linkBusy(linkBusy), .shuntSample(shuntSample), .scalingCalibration(cal),
    .alertMaskEnable(mask), .alertThreshold(limit), .convDone(convDone),
    .converting(converting));

  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // cycle ceiling and completion counter
  always @(posedge clk) begin
    cycles++;
    if (convDone === 1'b1) doneCnt++;
    if (cycles == 90000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic init_mdl();
    foreach (mdl[i]) mdl[i] = 16'h0000;
    mdl[pm_pkg::PTR_CONFIG] = pm_pkg::CONFIG_RESET;
    mdl[pm_pkg::PTR_MAKER] = MAKER_VAL;
    mdl[pm_pkg::PTR_DIE] = DIE_VAL;
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    i_host.write_reg(p, v, ok);
    chk("write handshake", 16'h0001, {15'h0000, ok});
    if (p == pm_pkg::PTR_CONFIG && v[15]) begin
      init_mdl();
    end else if (p == pm_pkg::PTR_CONFIG) begin
      mdl[p] = (pm_pkg::CONFIG_RESET & 16'h7000) | (v & 16'h0FFF);
    end else if (p == pm_pkg::PTR_CAL || p == pm_pkg::PTR_LIMIT) begin
      mdl[p] = v;
    end else if (p == pm_pkg::PTR_MASK) begin
      mdl[p] = v & pm_pkg::MASK_WRITABLE;
    end
    chk("calibration out", mdl[pm_pkg::PTR_CAL], cal);
    chk("threshold out", mdl[pm_pkg::PTR_LIMIT], limit);
    chk("mask out", mdl[pm_pkg::PTR_MASK], mask & 16'hFFF7);
  endtask

  task automatic rd(input logic [7:0] p, input logic [15:0] exp, input logic [15:0] ign);
    i_host.read_reg(p, rdata, ok);
    chk("read handshake", 16'h0001, {15'h0000, ok});
    chk($sformatf("read %h", p), exp & ~ign, rdata & ~ign);
  endtask

  // one new sample value per shunt conversion, changed mid-conversion
  task automatic feed();
    int n;
    n = 0;
    while (converting !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (CYC[0] / 2) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      #1 shuntSample = samp[k];
      repeat (CYC[0]) @(posedge clk);
    end
  endtask

  task automatic idle_check(input logic [15:0] cfg);
    wr(pm_pkg::PTR_CONFIG, cfg);
    rd(pm_pkg::PTR_CONFIG, mdl[0], 16'h0000);
    d0 = doneCnt;
    repeat (300) @(posedge clk);
    #1;
    chk("power-down converting", 16'h0000, {15'h0000, converting});
    chk("power-down done count", 16'h0000, 16'(doneCnt - d0));
  endtask

  initial begin
    init_mdl();
    fork
      i_host.reset_link();
      repeat (2) @(posedge clk);
    join
    @(posedge clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge clk);
    foreach (PTRS[i]) rd(PTRS[i], mdl[PTRS[i]], (i == 2) ? 16'h0008 : 16'h0000);
    idle_check(16'($random(seed) & 16'h7FF8));
    idle_check(16'(($random(seed) & 16'h7FF8) | 16'h0004));
    for (int i = 0; i < 9; i++) begin
      wr(RWP[i % 3], 16'($random(seed)));
      rd(RWP[i % 3], mdl[RWP[i % 3]], 16'h0008);
    end
    foreach (PTRS[i]) wr((i > 3) ? PTRS[i] : 8'h01 + 8'(i) * 8'h0F, 16'($random(seed)));
    rd(8'hFE, MAKER_VAL, 16'h0000);
    rd(8'hFF, DIE_VAL, 16'h0000);
    rd(8'h10, 16'h0000, 16'h0000);
    // triggered shunt, four averaged samples
    for (int k = 0; k < 4; k++) samp[k] = 16'($random(seed));
    samp[1] = -16'sd32000;
    s = 0;
    foreach (samp[k]) s += samp[k];
    d0 = doneCnt;
    fork
      wr(pm_pkg::PTR_CONFIG, 16'h0201);
      feed();
    join
    repeat (200) @(posedge clk);
    #1;
    chk("triggered done count", 16'h0001, 16'(doneCnt - d0));
    chk("triggered stops", 16'h0000, {15'h0000, converting});
    rd(pm_pkg::PTR_SHUNT, 16'(s >>> 2), 16'h0000);
    // triggered bus only: one set, shunt result untouched
    wr(pm_pkg::PTR_CONFIG, 16'h0002);
    repeat (100) @(posedge clk);
    chk("bus triggered done count", 16'h0002, 16'(doneCnt - d0));
    rd(pm_pkg::PTR_SHUNT, 16'(s >>> 2), 16'h0000);
    wr(pm_pkg::PTR_CONFIG, 16'h0004);
    rd(pm_pkg::PTR_MASK, mdl[6] | 16'h0008, 16'h0000);
    rd(pm_pkg::PTR_MASK, mdl[6], 16'h0000);
    wr(pm_pkg::PTR_CONFIG, 16'h0201);
    repeat (300) @(posedge clk);
    wr(pm_pkg::PTR_CONFIG, 16'h0E39);
    rd(pm_pkg::PTR_CONFIG, 16'h4E39, 16'h0000);
    chk("read keeps conversion", 16'h0001, {15'h0000, converting});
    rd(pm_pkg::PTR_MASK, mdl[6], 16'h0000);
    // soft reset
    wr(pm_pkg::PTR_CAL, 16'h5A5A);
    wr(pm_pkg::PTR_LIMIT, 16'hA5A5);
    d = 16'h8000 | 16'($random(seed));
    wr(pm_pkg::PTR_CONFIG, d);
    foreach (PTRS[i]) rd(PTRS[i], mdl[PTRS[i]], (i == 2) ? 16'h0008 : 16'h0000);
    d0 = doneCnt;
    repeat (2000) @(posedge clk);
    chk("continuous after reset", 16'h0001, {15'h0000, doneCnt > d0 + 2});
    test_done();
  end
endmodule // power_monitor_config_regs_tb_top
`default_nettype wire
